// File: shared/tws_map.vh
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TWS_CTRL_OFS   8'h00
`define TWS_STAT_OFS   8'h04
`define TWS_DATA_OFS   8'h08
`define TWS_RATE_OFS   8'h0C

// ****************************************
// Control register fields
// ****************************************
`define TWS_FLAG_BIT   7
`define TWS_ACKEN_BIT  6
`define TWS_STA_BIT    5
`define TWS_STO_BIT    4
`define TWS_WCOL_BIT   3
`define TWS_EN_BIT     2

// ****************************************
// Status register fields
// ****************************************
`define TWS_PRE_MSB    1
`define TWS_PRE_LSB    0

// ****************************************
// Reset values
// ****************************************
`define TWS_RATE_RST   8'h18
`define TWS_PRE_RST    2'h0
`define TWS_DATA_RST   8'hFF

// ****************************************
// Status codes, prescaler field zero
// ****************************************
`define TWS_SC_IDLE    8'hF8
`define TWS_SC_START   8'h08
`define TWS_SC_RSTART  8'h10
`define TWS_SC_AW_ACK  8'h18
`define TWS_SC_AW_NACK 8'h20
`define TWS_SC_DT_ACK  8'h28
`define TWS_SC_DT_NACK 8'h30
`define TWS_SC_ARB     8'h38
`define TWS_SC_AR_ACK  8'h40
`define TWS_SC_AR_NACK 8'h48
`define TWS_SC_DR_ACK  8'h50
`define TWS_SC_DR_NACK 8'h58

`endif

// File: hw/tws_sync2.v
`timescale 1ns/1ns
// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module tws_sync2 #(
  parameter WIDTH = 2
) (
  input  wire             clk,    // sampling clock
  input  wire             rst_n,  // async reset, active low
  input  wire [WIDTH-1:0] d,      // asynchronous input
  output reg  [WIDTH-1:0] q       // synchronised output
);
  reg [WIDTH-1:0] meta;

  // Reset to released-bus level so no false start is seen
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b1}};
      q    <= {WIDTH{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: hw/tws_tick.v
`timescale 1ns/1ns
// ****************************************
// Quarter-bit tick generator
// ****************************************
module tws_tick #(
  parameter CW = 16
) (
  input  wire          clk,    // system clock
  input  wire          rst_n,  // async reset, active low
  input  wire          run,    // count while a bus action runs
  input  wire          stall,  // hold count while clock is stretched
  input  wire [CW-1:0] limit,  // tick every limit+1 cycles
  output wire          tick    // one-cycle quarter-bit pulse
);
  reg [CW-1:0] cnt;

  assign tick = run & ~stall & (cnt >= limit);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= {CW{1'b0}};
    end else if (!run || tick) begin
      cnt <= {CW{1'b0}};
    end else if (!stall) begin
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// File: hw/tws_top.v
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
`include "tws_map.vh"
module tws_top (
  input  wire        pclk,      // system clock
  input  wire        presetn,   // async reset, active low
  input  wire        psel,      // APB select
  input  wire        penable,   // APB enable
  input  wire        pwrite,    // APB direction
  input  wire [7:0]  paddr,     // APB byte address
  input  wire [31:0] pwdata,    // APB write data
  output reg  [31:0] prdata,    // APB read data
  output wire        pready,    // APB ready
  output wire        pslverr,   // APB error on unmapped address
  input  wire        scl_in,    // serial clock pin level
  output wire        scl_out,   // serial clock drive value
  output wire        scl_oe_n,  // serial clock drive enable, low drives
  input  wire        sda_in,    // serial data pin level
  output wire        sda_out,   // serial data drive value
  output wire        sda_oe_n,  // serial data drive enable, low drives
  output wire        event_req  // service request toward software
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE  = 5'b00001;
  localparam ST_START = 5'b00010;
  localparam ST_BIT   = 5'b00100;
  localparam ST_HOLD  = 5'b01000;
  localparam ST_STOP  = 5'b10000;

  // ****************************************
  // Declarations
  // ****************************************
  reg  [4:0]  state;
  reg  [1:0]  phase;
  reg  [3:0]  bitn;
  reg         step_done_flag;
  reg         ack_enable_bit;
  reg         start_request_bit;
  reg         stop_request_bit;
  reg         write_collision_flag;
  reg         interface_enable_bit;
  reg  [1:0]  prescale;
  reg  [7:0]  rate;
  reg  [7:0]  status_code;
  reg  [7:0]  serial_byte_reg;
  reg  [7:0]  shift;
  reg         master_receive_mode;
  reg         is_addr;
  reg         owner;
  reg         nack_seen;
  reg         scl_low;
  reg         sda_low;
  reg         busy;
  reg         sda_q;
  wire [1:0]  pins_s;
  wire        scl_s;
  wire        sda_s;
  wire        tick;
  wire        run;
  wire        stall;
  wire [15:0] qlimit;
  wire        tx_byte;
  wire        intend_one;
  wire        lost;
  wire        acc;
  wire        wr;
  wire        hit_ctrl;
  wire        hit_stat;
  wire        hit_data;
  wire        hit_rate;
  wire        mapped;
  wire        wr_ctrl;
  wire        wr_data;
  reg  [31:0] rdata;

  // ****************************************
  // Pin interface
  // ****************************************
  // Open drain: the value is always low, only the enable moves
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = ~scl_low;
  assign sda_oe_n = ~sda_low;

  tws_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_in, sda_in}),
    .q     (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Bus busy tracking from start and stop conditions seen on the lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_q <= 1'b1;
      busy  <= 1'b0;
    end else begin
      sda_q <= sda_s;
      if (scl_s && sda_q && !sda_s) begin
        busy <= 1'b1;
      end else if (scl_s && !sda_q && sda_s) begin
        busy <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bit timing
  // ****************************************
  assign qlimit = {8'h00, rate} << {prescale, 1'b0};
  assign run    = (state == ST_START) || (state == ST_BIT) || (state == ST_STOP);
  // A slave stretching the clock freezes the count until the line rises
  assign stall  = run && (phase == 2'd2) && !scl_low && !scl_s;

  tws_tick #(
    .CW (16)
  ) u_tick (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (run),
    .stall (stall),
    .limit (qlimit),
    .tick  (tick)
  );

  // ****************************************
  // APB slave
  // ****************************************
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign hit_ctrl = (paddr == `TWS_CTRL_OFS);
  assign hit_stat = (paddr == `TWS_STAT_OFS);
  assign hit_data = (paddr == `TWS_DATA_OFS);
  assign hit_rate = (paddr == `TWS_RATE_OFS);
  assign mapped   = hit_ctrl | hit_stat | hit_data | hit_rate;
  assign wr_ctrl  = wr & hit_ctrl;
  assign wr_data  = wr & hit_data;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign event_req = step_done_flag & interface_enable_bit;

  always @* begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata[`TWS_FLAG_BIT]  = step_done_flag;
      rdata[`TWS_ACKEN_BIT] = ack_enable_bit;
      rdata[`TWS_STA_BIT]   = start_request_bit;
      rdata[`TWS_STO_BIT]   = stop_request_bit;
      rdata[`TWS_WCOL_BIT]  = write_collision_flag;
      rdata[`TWS_EN_BIT]    = interface_enable_bit;
    end else if (hit_stat) begin
      rdata[7:0] = {status_code[7:3], 1'b0, prescale};
    end else if (hit_data) begin
      rdata[7:0] = serial_byte_reg;
    end else if (hit_rate) begin
      rdata[7:0] = rate;
    end
  end

  // Read data is captured in the setup cycle so it stands in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata;
    end
  end

  // Software-only control fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interface_enable_bit <= 1'b0;
      ack_enable_bit       <= 1'b0;
      start_request_bit    <= 1'b0;
      prescale             <= `TWS_PRE_RST;
      rate                 <= `TWS_RATE_RST;
    end else if (wr) begin
      if (hit_ctrl) begin
        interface_enable_bit <= pwdata[`TWS_EN_BIT];
        ack_enable_bit       <= pwdata[`TWS_ACKEN_BIT];
        start_request_bit    <= pwdata[`TWS_STA_BIT];
      end
      if (hit_stat) begin
        prescale <= pwdata[`TWS_PRE_MSB:`TWS_PRE_LSB];
      end
      if (hit_rate) begin
        rate <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // Byte engine
  // ****************************************
  assign tx_byte    = is_addr | ~master_receive_mode;
  // Released line meant as one: a low reading means another master won
  assign intend_one = !sda_low && ((bitn < 4'd8) ? tx_byte : ~tx_byte);
  assign lost       = intend_one && !sda_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                <= ST_IDLE;
      phase                <= 2'd0;
      bitn                 <= 4'd0;
      step_done_flag       <= 1'b0;
      stop_request_bit     <= 1'b0;
      write_collision_flag <= 1'b0;
      status_code          <= `TWS_SC_IDLE;
      serial_byte_reg      <= `TWS_DATA_RST;
      shift                <= 8'h00;
      master_receive_mode  <= 1'b0;
      is_addr              <= 1'b0;
      owner                <= 1'b0;
      nack_seen            <= 1'b0;
      scl_low              <= 1'b0;
      sda_low              <= 1'b0;
    end else begin
      // Software side; hardware assignments further down win the same cycle
      if (wr_ctrl && pwdata[`TWS_FLAG_BIT]) begin
        step_done_flag <= 1'b0;
      end
      if (wr_ctrl) begin
        stop_request_bit <= pwdata[`TWS_STO_BIT];
      end
      if (wr_data) begin
        if (step_done_flag) begin
          serial_byte_reg      <= pwdata[7:0];
          write_collision_flag <= 1'b0;
        end else begin
          write_collision_flag <= 1'b1;
        end
      end
      if (!interface_enable_bit) begin
        state   <= ST_IDLE;
        phase   <= 2'd0;
        owner   <= 1'b0;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            phase <= 2'd0;
            if (start_request_bit && !step_done_flag && !busy) begin
              state <= ST_START;
            end
          end
          ST_HOLD: begin
            // Clock held low until software clears the flag
            phase <= 2'd0;
            if (!step_done_flag) begin
              if (stop_request_bit) begin
                state <= ST_STOP;
              end else if (start_request_bit) begin
                state <= ST_START;
              end else begin
                state <= ST_BIT;
                bitn  <= 4'd0;
                shift <= tx_byte ? serial_byte_reg : 8'hFF;
              end
            end
          end
          ST_START: begin
            if (tick) begin
              phase <= phase + 2'd1;
              case (phase)
                2'd0: sda_low <= 1'b0;
                2'd1: scl_low <= 1'b0;
                2'd2: sda_low <= 1'b1;
                default: begin
                  scl_low        <= 1'b1;
                  status_code    <= owner ? `TWS_SC_RSTART : `TWS_SC_START;
                  owner          <= 1'b1;
                  is_addr        <= 1'b1;
                  step_done_flag <= 1'b1;
                  state          <= ST_HOLD;
                end
              endcase
            end
          end
          ST_BIT: begin
            if (tick) begin
              phase <= phase + 2'd1;
              case (phase)
                2'd0: begin
                  if (bitn < 4'd8) begin
                    sda_low <= tx_byte & ~shift[7];
                  end else begin
                    sda_low <= ~tx_byte & ack_enable_bit;
                  end
                end
                2'd1: scl_low <= 1'b0;
                2'd2: begin
                  if (lost) begin
                    scl_low        <= 1'b0;
                    sda_low        <= 1'b0;
                    owner          <= 1'b0;
                    status_code    <= `TWS_SC_ARB;
                    step_done_flag <= 1'b1;
                    state          <= ST_IDLE;
                  end else if (bitn < 4'd8) begin
                    shift <= {shift[6:0], sda_s};
                  end else begin
                    nack_seen <= sda_s;
                  end
                end
                default: begin
                  scl_low <= 1'b1;
                  if (bitn < 4'd8) begin
                    bitn <= bitn + 4'd1;
                  end else begin
                    state          <= ST_HOLD;
                    step_done_flag <= 1'b1;
                    is_addr        <= 1'b0;
                    if (is_addr) begin
                      master_receive_mode <= serial_byte_reg[0];
                      if (serial_byte_reg[0]) begin
                        status_code <= nack_seen ? `TWS_SC_AR_NACK : `TWS_SC_AR_ACK;
                      end else if (nack_seen) begin
                        status_code <= `TWS_SC_AW_NACK;
                      end else begin
                        status_code <= `TWS_SC_AW_ACK;
                      end
                    end else if (master_receive_mode) begin
                      serial_byte_reg <= shift;
                      status_code     <= nack_seen ? `TWS_SC_DR_NACK : `TWS_SC_DR_ACK;
                    end else if (nack_seen) begin
                      status_code <= `TWS_SC_DT_NACK;
                    end else begin
                      status_code <= `TWS_SC_DT_ACK;
                    end
                  end
                end
              endcase
            end
          end
          ST_STOP: begin
            if (tick) begin
              phase <= phase + 2'd1;
              case (phase)
                2'd0: sda_low <= 1'b1;
                2'd1: scl_low <= 1'b0;
                2'd2: sda_low <= 1'b0;
                default: begin
                  // A pending start request restarts from idle once free
                  owner       <= 1'b0;
                  status_code <= `TWS_SC_IDLE;
                  state       <= ST_IDLE;
                  if (!(wr_ctrl && pwdata[`TWS_STO_BIT])) begin
                    stop_request_bit <= 1'b0;
                  end
                end
              endcase
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// File: verif/tws_top_sva.sv
`timescale 1ns/1ns
`include "tws_map.vh"
// ****************************************
// Step flag and bus condition checks
// ****************************************
module tws_top_sva (
  input wire        pclk,      // System clock
  input wire        presetn,   // Reset, active low
  input wire        psel,      // APB select
  input wire        penable,   // APB enable
  input wire        pwrite,    // APB direction
  input wire [7:0]  paddr,     // APB address
  input wire [31:0] pwdata,    // APB write data
  input wire [31:0] prdata,    // APB read data
  input wire        scl_oe_n,  // Clock drive enable
  input wire        sda_oe_n,  // Data drive enable
  input wire        event_req  // Service request
);
  wire ctrl_wr = psel & penable & pwrite & (paddr == `TWS_CTRL_OFS);
  wire stat_rd = psel & penable & !pwrite & (paddr == `TWS_STAT_OFS);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Data pulled low while the clock is released
  sequence s_start;
    $fell(sda_oe_n) && scl_oe_n;
  endsequence
  sequence s_stop;
    $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n);
  endsequence
  AST_START_HOLD: assert property (s_start |-> !sda_oe_n throughout (##[1:200] !scl_oe_n))
    else $error("start without clock low");
  AST_START_FLAG: assert property (s_start |-> ##[1:300] event_req)
    else $error("start without step flag");
  // Pins frozen while software services the flag
  AST_SUSPEND: assert property (event_req && $past(event_req) |-> $stable(scl_oe_n) && $stable(sda_oe_n))
    else $error("bus moved while suspended");
  AST_RESUME: assert property ($fell(event_req) |-> $past(ctrl_wr))
    else $error("flag dropped without control write");
  AST_FLAG_CLEAR: assert property (ctrl_wr && pwdata[7] && event_req |=> !event_req)
    else $error("flag clear ignored");
  AST_STAT_LAYOUT: assert property (stat_rd |-> prdata[31:8] == 24'h0 && !prdata[2])
    else $error("status layout wrong");
  AST_FLAG_CODE: assert property (stat_rd && event_req |-> prdata[7:3] != 5'h1F)
    else $error("idle code with flag set");
  AST_STOP: assert property (s_stop |-> !event_req ##1 (scl_oe_n && sda_oe_n))
    else $error("stop not clean");
endmodule

bind tws_top tws_top_sva u_tws_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .event_req(event_req));

// File: verif/tws_slave_model.sv
`timescale 1ns/1ns
// ****************************************
// Behavioural bus target
// ****************************************
module tws_slave_model #(
  parameter [6:0] ADDR = 7'h2A  // Arbitrary target address
) (
  input  wire       scl,        // Resolved clock line
  input  wire       sda,        // Resolved data line
  input  wire       ack_ok,     // Acknowledge address and written bytes
  input  wire [7:0] tx_byte,    // Byte returned on reads
  output reg        sda_low,    // Pull data line low
  output reg  [7:0] rx_byte,    // Last written byte
  output reg        master_ack  // Master answer after a read byte
);
  reg [3:0] bit_n = 4'h0;
  reg       active = 1'b0;
  reg       is_addr = 1'b0;
  reg       rd = 1'b0;
  reg [7:0] sh = 8'h00;
  reg [7:0] tx_sh = 8'h00;
  initial sda_low = 1'b0;
  initial rx_byte = 8'h00;
  initial master_ack = 1'b0;
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    is_addr = 1'b1;
    rd = 1'b0;
    bit_n = 4'h0;
  end
  always @(posedge sda) if (scl) begin
    active = 1'b0;
    sda_low = 1'b0;
  end
  always @(posedge scl) if (active) begin
    if (bit_n < 4'h8) sh = {sh[6:0], sda};
    else master_ack = !sda;
    bit_n = bit_n + 4'h1;
  end
  // sda_low and rx_byte change here while the clock is low; master_ack updates on the rising edge
  always @(negedge scl) if (active) begin
    if (bit_n == 4'h8) begin
      if (is_addr) begin
        rd = sh[0];
        active = (sh[7:1] == ADDR);
        sda_low = active & ack_ok;
      end else if (!rd) begin
        rx_byte = sh;
        sda_low = ack_ok;
      end else sda_low = 1'b0;
    end else if (bit_n == 4'h9) begin
      bit_n = 4'h0;
      tx_sh = tx_byte;
      // A not-acknowledge ends the read burst
      sda_low = rd && (is_addr ? ack_ok : master_ack) && !tx_byte[7];
      if (!(rd && (is_addr ? ack_ok : master_ack))) rd = 1'b0;
      is_addr = 1'b0;
    end else if (rd && !is_addr && bit_n != 4'h0) sda_low = !tx_sh[4'h7 - bit_n];
  end
endmodule

// File: verif/two_wire_master_sequencer_test.sv
`timescale 1ns/1ns
`include "tws_map.vh"
module two_wire_master_sequencer_test;
  localparam integer LIMIT = 30000;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        scl_out;
  wire        scl_oe_n;
  wire        sda_out;
  wire        sda_oe_n;
  wire        event_req;
  wire        slv_low;
  wire [7:0]  rx_byte;
  wire        master_ack;
  reg         ack_ok;
  reg  [7:0]  tx_byte;
  reg         arb_low;
  reg  [31:0] rd;
  reg         err;
  reg  [31:0] seed;
  reg  [7:0]  b;
  integer     mismatches;
  integer     num_checks;
  integer     cycles;
  integer     i;
  // Open-drain lines with pull-ups; arb_low is a rival master
  wire scl_line = scl_oe_n | scl_out;
  wire sda_line = (sda_oe_n | sda_out) & ~slv_low & ~arb_low;
  tws_top u_tws_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .event_req(event_req));
  tws_slave_model u_tws_slave_model (.scl(scl_line), .sda(sda_line), .ack_ok(ack_ok), .tx_byte(tx_byte),
    .sda_low(slv_low), .rx_byte(rx_byte), .master_ack(master_ack));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] sla(input [6:0] a, input r);
    sla = {a, r};
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control write, then wait for the step flag and fetch status
  task go(input [7:0] c);
    apb(1'b1, `TWS_CTRL_OFS, {24'h0, c});
    @(posedge pclk);
    while (event_req !== 1'b1) @(posedge pclk);
    apb(1'b0, `TWS_STAT_OFS, 32'h0);
    rd = rd & 32'hF8;
  endtask
  task stop_bus;
    apb(1'b1, `TWS_CTRL_OFS, 32'h94);
    rd = 32'h10;
    while (rd[4] !== 1'b0) apb(1'b0, `TWS_CTRL_OFS, 32'h0);
  endtask
  task complete_run;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack_ok = 1'b1;
    tx_byte = 8'h00;
    arb_low = 1'b0;
    seed = 32'hdc1d4c6e;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TWS_STAT_OFS, 32'h0);
    check(rd[7:0], `TWS_SC_IDLE);
    // Prescaler field reads back beside the code, so software must mask it
    apb(1'b1, `TWS_STAT_OFS, 32'h3);
    apb(1'b0, `TWS_STAT_OFS, 32'h0);
    check(rd[7:0], `TWS_SC_IDLE | 8'h03);
    apb(1'b1, `TWS_STAT_OFS, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    check({7'h0, err}, 8'h01);
    apb(1'b1, `TWS_DATA_OFS, 32'h5A);
    apb(1'b0, `TWS_CTRL_OFS, 32'h0);
    check(rd[7:0] & 8'h08, 8'h08);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd[7:0], `TWS_DATA_RST);
    apb(1'b1, `TWS_RATE_OFS, 32'h1);
    go(8'hA4);
    check(rd[7:0], `TWS_SC_START);
    apb(1'b1, `TWS_DATA_OFS, {24'h0, sla(7'h2A, 1'b0)});
    apb(1'b0, `TWS_CTRL_OFS, 32'h0);
    check(rd[7:0] & 8'h08, 8'h00);
    go(8'h84);
    check(rd[7:0], `TWS_SC_AW_ACK);
    for (i = 0; i < 4; i = i + 1) begin
      b = (i == 0) ? 8'hFF : seed[7:0];
      seed = lfsr(seed);
      apb(1'b1, `TWS_DATA_OFS, {24'h0, b});
      go(8'h84);
      check(rd[7:0], `TWS_SC_DT_ACK);
      check(rx_byte, b);
    end
    ack_ok <= 1'b0;
    apb(1'b1, `TWS_DATA_OFS, 32'h0);
    go(8'h84);
    check(rd[7:0], `TWS_SC_DT_NACK);
    ack_ok <= 1'b1;
    go(8'hA4);
    check(rd[7:0], `TWS_SC_RSTART);
    b = seed[7:0];
    seed = lfsr(seed);
    tx_byte <= b;
    apb(1'b1, `TWS_DATA_OFS, {24'h0, sla(7'h2A, 1'b1)});
    go(8'h84);
    check(rd[7:0], `TWS_SC_AR_ACK);
    go(8'hC4);
    check(rd[7:0], `TWS_SC_DR_ACK);
    check({7'h0, master_ack}, 8'h01);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd[7:0], b);
    go(8'h84);
    check(rd[7:0], `TWS_SC_DR_NACK);
    check({7'h0, master_ack}, 8'h00);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd[7:0], b);
    go(8'hB4);
    check(rd[7:0], `TWS_SC_START);
    apb(1'b0, `TWS_CTRL_OFS, 32'h0);
    check(rd[7:0] & 8'h10, 8'h00);
    apb(1'b1, `TWS_DATA_OFS, {24'h0, sla(7'h33, 1'b0)});
    go(8'h84);
    check(rd[7:0], `TWS_SC_AW_NACK);
    go(8'hA4);
    check(rd[7:0], `TWS_SC_RSTART);
    apb(1'b1, `TWS_DATA_OFS, {24'h0, sla(7'h33, 1'b1)});
    go(8'h84);
    check(rd[7:0], `TWS_SC_AR_NACK);
    stop_bus;
    apb(1'b0, `TWS_STAT_OFS, 32'h0);
    check({6'h0, sda_oe_n, scl_oe_n} | (rd[7:0] & 8'hF8), 8'hFB);
    go(8'hA4);
    check(rd[7:0], `TWS_SC_START);
    apb(1'b1, `TWS_DATA_OFS, 32'hFF);
    arb_low <= 1'b1;
    go(8'h84);
    check(rd[7:0], `TWS_SC_ARB);
    apb(1'b1, `TWS_CTRL_OFS, 32'h84);
    arb_low <= 1'b0;
    // The flag clear lands on the write edge; look one edge later
    @(posedge pclk);
    check({5'h0, event_req, sda_oe_n, scl_oe_n}, 8'h03);
    go(8'hA4);
    check(rd[7:0], `TWS_SC_START);
    stop_bus;
    complete_run;
  end
endmodule
